/* File: logic/sac_clkdiv.sv */
// converter clock tick generator from the system clock
`timescale 1ns/1ps
module sac_clkdiv
(
   input  wire logic       clk,     // system clock
   input  wire logic       rstn,    // async reset, active low
   input  wire logic       ce,      // clock enable
   input  wire logic       run,     // count while high
   input  wire logic [2:0] code,    // conversion clock field
   output logic            tick     // one-cycle pulse per converter period
);

   typedef struct packed {
      logic [5:0] cnt;
      logic       tick;
   } sac_div_state_t;

   sac_div_state_t s_r;
   sac_div_state_t s_nxt;

   assign tick = s_r.tick;

   // ------------------------------------------------------------
   // divider: restarts while idle so the first period is whole
   // ------------------------------------------------------------
   always_comb
   begin
      s_nxt      = s_r;
      s_nxt.tick = 1'b0;
      if (!run)
         s_nxt.cnt = 6'h00;
      else if (s_r.cnt == sac_pkg::div_period(code) - 6'h01)   // [R13]
      begin
         s_nxt.cnt  = 6'h00;
         s_nxt.tick = 1'b1;
      end
      else
         s_nxt.cnt = s_r.cnt + 6'h01;
   end

   // state register
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         s_r <= '0;
      else if (ce)
         s_r <= s_nxt;
   end

endmodule

/* File: logic/sac_pkg.sv */
// shared constants and carrier types for the converter control block
package sac_pkg;

   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL   = 8'h93;
   localparam logic [7:0] OFS_TIMING = 8'h94;
   localparam logic [7:0] OFS_PINS   = 8'h95;
   localparam logic [7:0] OFS_LOW    = 8'h96;
   localparam logic [7:0] OFS_HIGH   = 8'h97;
   localparam logic [7:0] OFS_ISTS   = 8'hA0;
   localparam logic [7:0] OFS_IMASK  = 8'hA1;

   // ------------------------------------------------------------
   // widths, timing and event bits
   // ------------------------------------------------------------
   localparam int         DATA_W      = 10;
   localparam logic [3:0] SAMPLE_MIN  = 4'h2;
   localparam logic [3:0] SAMPLE_MAX  = 4'hF;
   localparam logic [3:0] CONV_TICKS  = 4'hC;
   localparam logic [3:0] TRIAL_TICKS = 4'hA;
   localparam int         EV_DONE     = 0;
   localparam int         EV_CMP      = 1;
   localparam logic [9:0] TRIAL_MSB   = 10'h200;

   // ------------------------------------------------------------
   // register layouts and carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic       converter_on;
      logic       converter_event_flag;
      logic       compare_enable;
      logic       rsv;
      logic [2:0] input_channel_select;
      logic       go;
   } sac_ctrl_t;

   typedef struct packed {
      logic [2:0] conv_clock_divider;
      logic       rsv;
      logic [3:0] sample_length_field;
   } sac_timing_t;

   typedef struct packed {
      logic             done;
      logic [DATA_W-1:0] conversion_value;
   } sac_result_t;

   // converter clock period in system clocks: 2,4,6,8,12,16,24,32
   function automatic logic [5:0] div_period(input logic [2:0] code);
      logic [5:0] p;
      p = 6'h02;
      unique case (code)
         3'h0: p = 6'h02;
         3'h1: p = 6'h04;
         3'h2: p = 6'h06;
         3'h3: p = 6'h08;
         3'h4: p = 6'h0C;
         3'h5: p = 6'h10;
         3'h6: p = 6'h18;
         3'h7: p = 6'h20;
      endcase
      return p;
   endfunction

endpackage

/* File: logic/sac_sar_seq.sv */
// sample phase and successive-approximation sequencer
`timescale 1ns/1ps
module sac_sar_seq
(
   input  wire logic                    clk,      // system clock
   input  wire logic                    rstn,     // async reset, active low
   input  wire logic                    ce,       // clock enable
   input  wire logic                    run,      // go and converter on
   input  wire logic                    repeat_en,// compare mode: loop passes
   input  wire logic                    tick,     // converter clock tick
   input  wire logic [3:0]              ts,       // sample length field
   input  wire logic                    cmp_in,   // analog above trial code
   output logic                         sampling, // sample switch closed
   output logic [sac_pkg::DATA_W-1:0]   trial,    // trial code to the dac
   output sac_pkg::sac_result_t         result    // done pulse and value
);

   typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONV} sac_seq_st_t;

   typedef struct packed {
      sac_seq_st_t               st;
      logic [3:0]                cnt;
      logic [sac_pkg::DATA_W-1:0] code;
      logic                      samp;
      sac_pkg::sac_result_t      res;
   } sac_seq_state_t;

   sac_seq_state_t s_r;
   sac_seq_state_t s_nxt;
   logic [3:0]     samp_len;
   logic [3:0]     bit_idx;

   assign sampling = s_r.samp;
   assign trial    = s_r.code;
   assign result   = s_r.res;

   // ------------------------------------------------------------
   // sample length: field plus one, held inside two..fifteen
   // ------------------------------------------------------------
   always_comb
   begin
      samp_len = ts + 4'h1;                                   // [R14]
      if (ts == sac_pkg::SAMPLE_MAX)
         samp_len = sac_pkg::SAMPLE_MAX;                      // [R2]
      if (samp_len < sac_pkg::SAMPLE_MIN)
         samp_len = sac_pkg::SAMPLE_MIN;                      // [R1]
      bit_idx = 4'h9 - s_r.cnt;
   end

   // ------------------------------------------------------------
   // sequencer; dropping run aborts any pass at once
   // ------------------------------------------------------------
   always_comb
   begin
      s_nxt          = s_r;
      s_nxt.res.done = 1'b0;
      if (!run)
      begin
         s_nxt.st  = ST_IDLE;                                 // [R15]
         s_nxt.cnt = 4'h0;
      end
      else
      begin
         unique case (s_r.st)
            ST_IDLE:
               // hold off one cycle after a done so the cleared go lands first
               if (!s_r.res.done)
               begin
                  s_nxt.st  = ST_SAMPLE;
                  s_nxt.cnt = 4'h0;
               end
            ST_SAMPLE:
               if (tick)
               begin
                  s_nxt.cnt = s_r.cnt + 4'h1;
                  if (s_r.cnt == samp_len - 4'h1)
                  begin
                     s_nxt.st   = ST_CONV;
                     s_nxt.cnt  = 4'h0;
                     s_nxt.code = sac_pkg::TRIAL_MSB;
                  end
               end
            ST_CONV:
               if (tick)
               begin
                  s_nxt.cnt = s_r.cnt + 4'h1;
                  // one bit decided per converter period, msb first
                  if (s_r.cnt < sac_pkg::TRIAL_TICKS)
                  begin
                     s_nxt.code[bit_idx] = cmp_in;
                     if (bit_idx != 4'h0)
                        s_nxt.code[bit_idx-4'h1] = 1'b1;
                  end
                  if (s_r.cnt == sac_pkg::CONV_TICKS - 4'h1)  // [R3]
                  begin
                     s_nxt.res.done             = 1'b1;
                     s_nxt.res.conversion_value = s_r.code;
                     s_nxt.cnt                  = 4'h0;
                     // compare mode starts a full new pass
                     s_nxt.st = repeat_en ? ST_SAMPLE : ST_IDLE;  // [R18]
                  end
               end
            default:
               s_nxt.st = ST_IDLE;
         endcase
      end
      s_nxt.samp = (s_nxt.st == ST_SAMPLE);
   end

   // state register
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         s_r <= '{st: ST_IDLE, default: '0};
      else if (ce)
         s_r <= s_nxt;
   end

endmodule

/* File: logic/sac_top.sv */
// converter control: registers, sequencing, compare and interrupt
//
// Operation
// R1: sample phase at least two converter periods
// R2: sample phase at most fifteen converter periods
// R3: conversion is sample plus twelve periods
// R4: pin bit one selects analog input
// R5: result split high eight, low two
// R6: compare mode keeps data registers as threshold
// R7: software starts with go after setup
// R8: done clears go, sets flag, interrupt
// R9: each single conversion needs new start
// R10: compare setup precedes enable and start
// R11: compare sets flag when input exceeds threshold
// R12: compare repeats until go cleared
// R13: divider field picks converter clock period
// R14: sample length is field plus one
// R15: clearing go aborts conversion
// R16: channel field routes one of eight inputs
// R17: result, go clear, flag same cycle
// R18: each compare pass is full conversion
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
module sac_top
(
   input  wire logic                  clk,         // system clock, 100 MHz
   input  wire logic                  rstn,        // async reset, active low
   input  wire logic                  ce,          // clock enable, freezes all
   input  wire logic [7:0]            addr,        // register address
   input  wire logic [7:0]            wdata,       // write data
   input  wire logic                  wr,          // write strobe
   input  wire logic                  rd,          // read strobe
   output logic      [7:0]            rdata,       // read data, next cycle
   output logic                       irq,         // interrupt level
   input  wire logic                  cmp_in,      // analog above trial code
   output logic      [9:0]            dac_code,    // trial code to the dac
   output logic                       sample_en,   // sample switch closed
   output logic      [2:0]            chan_sel,    // input mux select
   output logic      [7:0]            pin_analog,  // per-pin analog enable
   output logic                       converter_on // analog power enable
);

   // ------------------------------------------------------------
   // state of the register side
   // ------------------------------------------------------------
   typedef struct packed {
      sac_pkg::sac_ctrl_t   ctrl;
      sac_pkg::sac_timing_t tim;
      logic [7:0]           pins;
      logic [7:0]           data_hi;
      logic [1:0]           data_lo;
      logic [1:0]           ists;
      logic [1:0]           imask;
      logic [7:0]           rdata;
      logic                 irq;
   } sac_top_state_t;

   sac_top_state_t       s_r;
   sac_top_state_t       s_nxt;
   logic                 tick;
   logic                 run;
   sac_pkg::sac_result_t res;
   logic [9:0]           threshold;

   // ------------------------------------------------------------
   // address decode, used by both read and write paths
   // ------------------------------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction

   // converter runs only while enabled and started
   assign run       = s_r.ctrl.go & s_r.ctrl.converter_on;   // [R7]
   assign threshold = {s_r.data_hi, s_r.data_lo};

   // outputs straight from registers
   assign rdata        = s_r.rdata;
   assign irq          = s_r.irq;
   assign chan_sel     = s_r.ctrl.input_channel_select;      // [R16]
   assign pin_analog   = s_r.pins;                           // [R4]
   assign converter_on = s_r.ctrl.converter_on;

   // ------------------------------------------------------------
   // converter clock and sequencer
   // ------------------------------------------------------------
   sac_clkdiv u_div
   (
      .clk  (clk),
      .rstn (rstn),
      .ce   (ce),
      .run  (run),
      .code (s_r.tim.conv_clock_divider),
      .tick (tick)
   );

   sac_sar_seq u_seq
   (
      .clk       (clk),
      .rstn      (rstn),
      .ce        (ce),
      .run       (run),
      .repeat_en (s_r.ctrl.compare_enable),
      .tick      (tick),
      .ts        (s_r.tim.sample_length_field),
      .cmp_in    (cmp_in),
      .sampling  (sample_en),
      .trial     (dac_code),
      .result    (res)
   );

   // ------------------------------------------------------------
   // next state: reads, writes, then hardware events
   // ------------------------------------------------------------
   always_comb
   begin
      s_nxt       = s_r;
      s_nxt.rdata = 8'h00;

      // read data stand only in the cycle after the strobe
      if (rd)
      begin
         if (hit(addr, sac_pkg::OFS_CTRL))
            s_nxt.rdata = {s_r.ctrl.converter_on,
                           s_r.ctrl.converter_event_flag,
                           s_r.ctrl.compare_enable, 1'b0,
                           s_r.ctrl.input_channel_select,
                           s_r.ctrl.go};
         else if (hit(addr, sac_pkg::OFS_TIMING))
            s_nxt.rdata = {s_r.tim.conv_clock_divider, 1'b0,
                           s_r.tim.sample_length_field};
         else if (hit(addr, sac_pkg::OFS_PINS))
            s_nxt.rdata = s_r.pins;
         else if (hit(addr, sac_pkg::OFS_LOW))
            s_nxt.rdata = {6'h00, s_r.data_lo};
         else if (hit(addr, sac_pkg::OFS_HIGH))
            s_nxt.rdata = s_r.data_hi;
         else if (hit(addr, sac_pkg::OFS_ISTS))
            s_nxt.rdata = {6'h00, s_r.ists};
         else if (hit(addr, sac_pkg::OFS_IMASK))
            s_nxt.rdata = {6'h00, s_r.imask};
      end

      // software writes; unmapped addresses are ignored
      if (wr)
      begin
         if (hit(addr, sac_pkg::OFS_CTRL))
         begin
            s_nxt.ctrl     = wdata;
            s_nxt.ctrl.rsv = 1'b0;
            // clearing go here aborts a pass in progress
         end
         if (hit(addr, sac_pkg::OFS_TIMING))
         begin
            s_nxt.tim     = wdata;
            s_nxt.tim.rsv = 1'b0;
         end
         if (hit(addr, sac_pkg::OFS_PINS))
            s_nxt.pins = wdata;                               // [R4]
         // threshold is loaded here before compare starts
         if (hit(addr, sac_pkg::OFS_LOW))
            s_nxt.data_lo = wdata[1:0];                       // [R10]
         if (hit(addr, sac_pkg::OFS_HIGH))
            s_nxt.data_hi = wdata;                            // [R10]
         if (hit(addr, sac_pkg::OFS_ISTS))
            s_nxt.ists = s_r.ists & ~wdata[1:0];
         if (hit(addr, sac_pkg::OFS_IMASK))
            s_nxt.imask = wdata[1:0];
      end

      // events come last so a hardware event beats a software write in the same cycle
      if (res.done && s_r.ctrl.go)
      begin
         if (!s_r.ctrl.compare_enable)
         begin
            // result, go clear and flag land together
            s_nxt.data_hi = res.conversion_value[9:2];        // [R5] [R17]
            s_nxt.data_lo = res.conversion_value[1:0];        // [R5]
            s_nxt.ctrl.go = 1'b0;                             // [R8] [R9]
            s_nxt.ctrl.converter_event_flag = 1'b1;           // [R8] [R17]
            s_nxt.ists[sac_pkg::EV_DONE]    = 1'b1;           // [R8]
         end
         // compare mode leaves data and go untouched
         else if (res.conversion_value > threshold)           // [R6] [R12]
         begin
            s_nxt.ctrl.converter_event_flag = 1'b1;           // [R11]
            s_nxt.ists[sac_pkg::EV_CMP]     = 1'b1;           // [R11]
         end
      end

      // interrupt level follows unmasked sticky status
      s_nxt.irq = |(s_nxt.ists & s_nxt.imask);                // [R8]
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         s_r <= '0;
      else if (ce)
         s_r <= s_nxt;
   end

endmodule

/* File: test/sac_afe_model.sv */
// analog front end: channel levels, sample-hold and comparator
`timescale 1ns/1ps
module sac_afe_model
(
   input  wire logic        clk,        // system clock
   input  wire logic [79:0] levels,     // eight 10-bit channel levels
   input  wire logic [2:0]  chan_sel,   // input mux select
   input  wire logic [7:0]  pin_analog, // per-pin analog enable
   input  wire logic        sample_en,  // sample switch closed
   input  wire logic [9:0]  dac_code,   // trial code
   output logic             cmp_in      // held input at or above trial
);
   logic [9:0] held = 10'h000;  // held sample, kept between conversions

   // a pin left in port mode never reaches the converter, so it samples zero
   always @(posedge clk)
      if (sample_en)
         held <= pin_analog[chan_sel] ? levels[chan_sel*10 +: 10] : 10'h000;

   assign cmp_in = (held >= dac_code);
endmodule

/* File: test/sac_assertions.sv */
// port-level checks for the converter control block
`timescale 1ns/1ps
module sac_checker
(
   input  wire logic       clk,        // system clock
   input  wire logic       rstn,       // async reset, active low
   input  wire logic [7:0] addr,       // register address
   input  wire logic [7:0] wdata,      // write data
   input  wire logic       wr,         // write strobe
   input  wire logic       irq,        // interrupt level
   input  wire logic [9:0] dac_code,   // trial code
   input  wire logic       sample_en,  // sample switch closed
   input  wire logic [2:0] chan_sel,   // input mux select
   input  wire logic [7:0] pin_analog  // per-pin analog enable
);
   logic [8:0] smp_cnt_r;  // cycles spent in the current sample phase
   logic [8:0] gap_cnt_r;  // cycles since the sample phase ended
   logic [2:0] wchan;      // channel field of the write data

   assign wchan = wdata[3:1];

   // ----------------------------------------------------------
   // helper counters; the gap counter saturates so long idles never wrap
   // ----------------------------------------------------------
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         smp_cnt_r <= 9'h000;
         gap_cnt_r <= 9'h000;
      end
      else
      begin
         smp_cnt_r <= sample_en ? smp_cnt_r + 9'h001 : 9'h000;
         gap_cnt_r <= sample_en ? 9'h000 : (gap_cnt_r == 9'h1FF) ? gap_cnt_r
                                                                  : gap_cnt_r + 9'h001;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   // ----------------------------------------------------------
   // assertions
   // ----------------------------------------------------------
   sample_min_a: assert property (
      $rose(sample_en) |-> sample_en [*4]) else $error("sample phase too short");
   sample_max_a: assert property (
      smp_cnt_r <= 9'h1E0) else $error("sample phase too long");
   conv_len_a: assert property (
      $rose(irq) |-> gap_cnt_r >= 9'h014 && gap_cnt_r <= 9'h18B)
      else $error("completion not twelve periods after sampling");
   dac_start_a: assert property (
      $fell(sample_en) |-> ##[0:40] dac_code == 10'h200) else $error("no first trial code");
   dac_quiet_a: assert property (
      sample_en && $past(sample_en) |-> $stable(dac_code)) else $error("trial moved in sampling");
   pin_follow_a: assert property (
      wr && addr == sac_pkg::OFS_PINS |-> ##2 pin_analog == $past(wdata, 2))
      else $error("pin enables do not follow write");
   chan_follow_a: assert property (
      wr && addr == sac_pkg::OFS_CTRL |-> ##2 chan_sel == $past(wchan, 2))
      else $error("channel select does not follow write");
   abort_quiet_a: assert property (
      wr && addr == sac_pkg::OFS_CTRL && !wdata[0] |-> ##3 (!sample_en && !$rose(irq)) [*8])
      else $error("activity after go cleared");

   // main scenarios reached
   cover property ($rose(irq));
   cover property ($fell(sample_en));
   cover property (wr && addr == sac_pkg::OFS_CTRL && wdata[5]);
endmodule

bind sac_top sac_checker u_chk (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
   .irq(irq), .dac_code(dac_code), .sample_en(sample_en), .chan_sel(chan_sel),
   .pin_analog(pin_analog));

/* File: test/tb_top.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_top;
   logic        clk;
   logic        rstn;
   logic [7:0]  addr;
   logic [7:0]  wdata;
   logic        wr;
   logic        rd;
   logic [7:0]  rdata;
   logic        irq;
   logic        cmp_in;
   logic [9:0]  dac_code;
   logic        sample_en;
   logic [2:0]  chan_sel;
   logic [7:0]  pin_analog;
   logic        smp_q;
   logic        conv_on;
   logic [79:0] levels = {10'h3FF, 10'h001, 10'h155, 10'h2A5,
                          10'h200, 10'h0FF, 10'h17C, 10'h000};
   logic [7:0]  pin_en = 8'hEF;   // channel 4 stays a port pin
   logic [7:0]  offs[8] = '{8'h93, 8'h94, 8'h95, 8'h96, 8'h97, 8'hA0, 8'hA1, 8'h50};
   logic [3:0]  ts_tab[8] = '{4'h0, 4'hF, 4'h7, 4'hE, 4'h1, 4'h3, 4'h2, 4'h0};
   int          per[8] = '{2, 4, 6, 8, 12, 16, 24, 32};
   int          errors;
   int          checks;
   int          passes;

   sac_top u_dut (.clk(clk), .rstn(rstn), .ce(1'b1), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .irq(irq), .cmp_in(cmp_in), .dac_code(dac_code),
      .sample_en(sample_en), .chan_sel(chan_sel), .pin_analog(pin_analog),
      .converter_on(conv_on));
   sac_afe_model u_afe (.clk(clk), .levels(levels), .chan_sel(chan_sel),
      .pin_analog(pin_analog), .sample_en(sample_en), .dac_code(dac_code), .cmp_in(cmp_in));

   // ----------------------------------------------------------
   // clock, pass counter, watchdog
   // ----------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // counts sample phases started, to see compare passes repeat
   always @(posedge clk)
   begin
      smp_q <= sample_en;
      if (sample_en && !smp_q)
         passes++;
   end

   // about ten times the expected run, so a hang ends the run cleanly
   initial
   begin
      #300000;
      errors++;
      report_and_stop();
   end

   // ----------------------------------------------------------
   // access tasks
   // ----------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what,
                         input logic [7:0] m = 8'hFF);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check({8'h00, rdata & m}, {8'h00, exp}, what);
   endtask

   task automatic run_conv(input logic [2:0] dv, input logic [3:0] ts, input logic [2:0] ch);
      int n;
      int e;
      logic [9:0] v;
      e = (ts == 4'hF) ? 15 : (ts == 4'h0) ? 2 : ts + 1;
      e = (e + 12) * per[dv] + 3;
      v = pin_en[ch] ? levels[ch*10 +: 10] : 10'h000;
      wr_reg(sac_pkg::OFS_TIMING, {dv, 1'b0, ts});
      wr_reg(sac_pkg::OFS_CTRL, {4'h8, ch, 1'b1});
      n = 0;
      while (irq !== 1'b1 && n < 2000)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      check(16'(n >= e - 4 && n <= e + 4), 16'h0001, "conversion time");
      rd_chk(sac_pkg::OFS_HIGH, v[9:2], "high byte");
      rd_chk(sac_pkg::OFS_LOW, {6'h00, v[1:0]}, "low byte");
      rd_chk(sac_pkg::OFS_CTRL, {4'hC, ch, 1'b0}, "control after done");
      check({15'h0000, conv_on}, 16'h0001, "converter on");
      rd_chk(sac_pkg::OFS_ISTS, 8'h01, "status after done");
      wr_reg(sac_pkg::OFS_ISTS, 8'h01);
      wr_reg(sac_pkg::OFS_CTRL, {4'h8, ch, 1'b0});
      repeat (12) @(posedge clk);
      check({15'h0000, irq}, 16'h0000, "irq after clear");
   endtask

   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // ----------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------
   initial
   begin
      rstn = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      for (int i = 0; i < 8; i++)
         rd_chk(offs[i], 8'h00, "reset value");
      wr_reg(sac_pkg::OFS_TIMING, 8'hFF);
      rd_chk(sac_pkg::OFS_TIMING, 8'hEF, "timing readback");
      wr_reg(sac_pkg::OFS_PINS, pin_en);
      rd_chk(sac_pkg::OFS_PINS, pin_en, "pin enables");
      check({8'h00, pin_analog}, {8'h00, pin_en}, "pin outputs");
      wr_reg(sac_pkg::OFS_IMASK, 8'h01);
      // every clock code and every channel, one port-mode pin among them
      for (int i = 0; i < 8; i++)
         run_conv(3'(i), ts_tab[i], 3'(i * 3));
      // abort early in the conversion phase
      wr_reg(sac_pkg::OFS_TIMING, 8'hE0);
      wr_reg(sac_pkg::OFS_CTRL, 8'h87);
      repeat (120) @(posedge clk);
      wr_reg(sac_pkg::OFS_CTRL, 8'h86);
      repeat (500) @(posedge clk);
      check({15'h0000, irq}, 16'h0000, "irq after abort");
      rd_chk(sac_pkg::OFS_ISTS, 8'h00, "status after abort");
      rd_chk(sac_pkg::OFS_HIGH, levels[59:52], "data after abort");
      // compare mode, masked: above threshold, then equal to it
      wr_reg(sac_pkg::OFS_IMASK, 8'h00);
      wr_reg(sac_pkg::OFS_TIMING, 8'h00);
      for (int k = 0; k < 2; k++)
      begin
         wr_reg(sac_pkg::OFS_CTRL, 8'h24);
         wr_reg(sac_pkg::OFS_HIGH, 8'h3F);
         wr_reg(sac_pkg::OFS_LOW, {6'h00, 1'b1, k[0]});
         repeat (12) @(posedge clk);
         passes = 0;
         wr_reg(sac_pkg::OFS_CTRL, 8'hA5);
         repeat (300) @(posedge clk);
         check(16'(passes >= 3), 16'h0001, "compare passes");
         rd_chk(sac_pkg::OFS_CTRL, k ? 8'hA5 : 8'hE5, "compare control");
         rd_chk(sac_pkg::OFS_ISTS, k ? 8'h00 : 8'h02, "compare status", 8'h02);
         rd_chk(sac_pkg::OFS_HIGH, 8'h3F, "threshold high");
         rd_chk(sac_pkg::OFS_LOW, {6'h00, 1'b1, k[0]}, "threshold low");
         check({15'h0000, irq}, 16'h0000, "masked irq");
         // stop during a conversion phase so no sample phase is cut short
         wait (sample_en === 1'b1);
         @(negedge sample_en);
         wr_reg(sac_pkg::OFS_CTRL, 8'h24);
         wr_reg(sac_pkg::OFS_ISTS, 8'h03);
         passes = 0;
         repeat (60) @(posedge clk);
         check(16'(passes), 16'h0000, "passes settled");
      end
      check({15'h0000, conv_on}, 16'h0000, "converter off");
      report_and_stop();
   end
endmodule
